/* rtl/cycle_bridge_timing.sv */
`timescale 1ns/1ps
// Operation
// - Target cycle starts one clock after host start; that clock decodes function codes.
// - Host cycle ends zero to two clocks after last target cycle.
// - Target transaction at least four clocks; bridged transaction five to seven.
// - Sixteen-bit mode: byte/word one transaction; longword split in two.
// - Eight-bit mode: word two transactions, longword four, line fill sixteen.
// - Burst line fill served as series of complete target transactions.
// - Sixteen-bit mode longword always takes two target transactions.
// - Width select low means 8-bit target bus, high means 16-bit.
// - Only lower 24 address bits are forwarded to the target.
module cycle_bridge_timing #(
	parameter int FIFO_DEPTH = cbt_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic widthSelect,
	input wire logic burst_inhibit_input,
	input wire logic auto_acknowledge_input,
	input wire logic reqValid,
	output logic reqReady,
	input wire cbt_pkg::cbt_req_t reqData,
	output logic hostDone,
	output logic [cbt_pkg::HOST_DW-1:0] hostRdata,
	output logic protocolError,
	output logic tgtStrobe,
	output cbt_pkg::cbt_tgt_t tgtOut,
	input wire logic target_transfer_ack,
	input wire logic [cbt_pkg::TGT_DW-1:0] tgtRdata
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_DECODE = 5'h02,
		ST_TARGET = 5'h04,
		ST_STEP = 5'h08,
		ST_TAIL = 5'h10
	} cbt_state_t;

	typedef struct packed {
		cbt_state_t state;
		cbt_pkg::cbt_req_t req;
		logic [3:0] beat;
		logic [3:0] beats;
		logic [1:0] tail;
		logic [cbt_pkg::HOST_DW-1:0] rdata;
		logic hostDone;
		logic protocolError;
		logic tgtStrobe;
		cbt_pkg::cbt_tgt_t tgt;
	} cbt_top_state_t;

	cbt_top_state_t st, next_st;
	logic fifoValid, fifoReady;
	cbt_pkg::cbt_req_t fifoData;

	// Host requests queue here so the host side stalls on reqReady only once the queue is full while the slow target runs.
	cbt_fifo #(.WIDTH($bits(cbt_pkg::cbt_req_t)), .DEPTH(FIFO_DEPTH)) reqFifo (
		.clk_sys(clk_sys),
		.srst(srst),
		.inValid(reqValid),
		.inReady(reqReady),
		.inData(reqData),
		.outValid(fifoValid),
		.outReady(fifoReady),
		.outData(fifoData)
	);

	// Number of target transactions for one host access; a line is four longwords.
	function automatic logic [3:0] beatCount(input logic [1:0] size, input logic wide);
		logic [3:0] perLong;
		perLong = wide ? 4'h2 : 4'h4;
		case (size)
			cbt_pkg::SIZE_BYTE: beatCount = 4'h1;
			cbt_pkg::SIZE_WORD: beatCount = wide ? 4'h1 : 4'h2;
			cbt_pkg::SIZE_LONG: beatCount = perLong;
			default: beatCount = wide ? 4'h8 : 4'h0;
		endcase
	endfunction

	// Host byte address of a given target beat.
	function automatic logic [cbt_pkg::TGT_AW-1:0] beatAddr(input logic [cbt_pkg::HOST_AW-1:0] base,
		input logic [3:0] beat, input logic wide);
		logic [cbt_pkg::TGT_AW-1:0] off;
		off = wide ? {{(cbt_pkg::TGT_AW-5){1'b0}}, beat, 1'b0} : {{(cbt_pkg::TGT_AW-4){1'b0}}, beat};
		beatAddr = base[cbt_pkg::TGT_AW-1:0] + off;
	endfunction

	always_comb begin
		logic wide;
		logic lastBeat;
		logic [cbt_pkg::TGT_AW-1:0] a;
		wide = widthSelect == cbt_pkg::WIDTH_16;
		lastBeat = (st.beat + 4'h1) == st.beats;
		a = beatAddr(st.req.addr, st.beat, wide);
		next_st = st;
		next_st.hostDone = 1'b0;
		fifoReady = 1'b0;
		// The pins are judged when the request enters the queue, not when it is served later.
		next_st.protocolError = st.protocolError | (reqValid & reqReady & (!burst_inhibit_input | !auto_acknowledge_input));
		case (st.state)
			ST_IDLE: begin
				if (fifoValid) begin
					fifoReady = 1'b1;
					next_st.req = fifoData;
					next_st.beat = 4'h0;
					next_st.beats = beatCount(fifoData.size, wide);
					// A 4'h0 in 8-bit mode means sixteen beats.
					if (!wide && fifoData.size == cbt_pkg::SIZE_LINE) begin
						next_st.beats = 4'h0;
					end
					next_st.rdata = '0;
					next_st.state = ST_DECODE;
				end
			end
			ST_DECODE: begin
				// The decode clock turns the attribute bit into function codes before the target starts.
				next_st.tgt.fc = st.req.attr ? cbt_pkg::FC_PROG[2:0] : cbt_pkg::FC_DATA[2:0];
				next_st.tgt.addr = a;
				next_st.tgt.write = st.req.write;
				next_st.tgt.upperStrobe = wide ? !(st.req.size == cbt_pkg::SIZE_BYTE && a[0]) : !a[0];
				next_st.tgt.lowerStrobe = wide ? !(st.req.size == cbt_pkg::SIZE_BYTE && !a[0]) : a[0];
				if (wide) begin
					next_st.tgt.wdata = st.beat[0] ? st.req.wdata[15:0] : st.req.wdata[31:16];
				end else begin
					next_st.tgt.wdata = {8'h00, st.req.wdata[8*(3-st.beat[1:0]) +: 8]};
				end
				next_st.tgtStrobe = 1'b1;
				next_st.state = ST_TARGET;
			end
			ST_TARGET: begin
				// Target needs its own four clocks; the ack marks the end of each one.
				if (target_transfer_ack) begin
					next_st.tgtStrobe = 1'b0;
					if (wide) begin
						next_st.rdata = {st.rdata[15:0], tgtRdata};
					end else begin
						next_st.rdata = {st.rdata[23:0], tgtRdata[7:0]};
					end
					next_st.beat = st.beat + 4'h1;
					if (lastBeat) begin
						next_st.tail = st.req.write ? cbt_pkg::TAIL_WRITE_LAST : cbt_pkg::TAIL_READ_LAST;
						next_st.state = (next_st.tail == 2'h0) ? ST_STEP : ST_TAIL;
					end else begin
						next_st.tail = st.req.write ? cbt_pkg::TAIL_WRITE_MID : cbt_pkg::TAIL_READ_MID;
						next_st.state = (next_st.tail == 2'h0) ? ST_DECODE : ST_TAIL;
					end
				end
			end
			ST_TAIL: begin
				// Trailing host clocks differ for reads and writes on earlier beats; the final beat trails the same count for both.
				next_st.tail = st.tail - 2'h1;
				if (st.tail == 2'h1) begin
					next_st.state = (st.beat == st.beats) ? ST_STEP : ST_DECODE;
				end
			end
			ST_STEP: begin
				next_st.hostDone = 1'b1;
				next_st.state = ST_IDLE;
			end
			default: begin
				next_st.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st <= '0;
			st.state <= ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign hostDone = st.hostDone;
	assign hostRdata = st.rdata;
	assign protocolError = st.protocolError;
	assign tgtStrobe = st.tgtStrobe;
	assign tgtOut = st.tgt;
endmodule

/* rtl/cbt_pkg.sv */
package cbt_pkg;
	localparam int HOST_AW = 32;
	localparam int HOST_DW = 32;
	localparam int TGT_AW = 24;
	localparam int TGT_DW = 16;
	localparam int FIFO_DEPTH = 8;
	// Transfer size codes on the host side.
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_LINE = 2'h3;
	localparam logic WIDTH_8 = 1'h0;
	localparam logic WIDTH_16 = 1'h1;
	// Host clocks that trail a target acknowledge; LAST values follow the final one before the host cycle ends, MID values the others.
	localparam logic [1:0] TAIL_READ_LAST = 2'h2;
	localparam logic [1:0] TAIL_WRITE_LAST = 2'h2;
	localparam logic [1:0] TAIL_READ_MID = 2'h1;
	localparam logic [1:0] TAIL_WRITE_MID = 2'h0;
	localparam logic [3:0] FC_DATA = 4'h1;
	localparam logic [3:0] FC_PROG = 4'h2;

	typedef struct packed {
		logic [HOST_AW-1:0] addr;
		logic [1:0] size;
		logic write;
		logic attr;
		logic [HOST_DW-1:0] wdata;
	} cbt_req_t;

	typedef struct packed {
		logic [TGT_AW-1:0] addr;
		logic [2:0] fc;
		logic write;
		logic [TGT_DW-1:0] wdata;
		logic upperStrobe;
		logic lowerStrobe;
	} cbt_tgt_t;
endpackage

/* rtl/cbt_fifo.sv */
`timescale 1ns/1ps
module cbt_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wrPtr;
		logic [AW:0] rdPtr;
		logic ready;
	} cbt_fifo_state_t;
	cbt_fifo_state_t st, next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full, empty;

	assign empty = st.wrPtr == st.rdPtr;
	// Ready is registered from the next pointers so the port comes straight from a flip-flop.
	assign full = !st.ready;
	assign inReady = st.ready;
	assign outValid = !empty;
	assign outData = mem[st.rdPtr[AW-1:0]];

	always_comb begin
		next_st = st;
		if (inValid && !full) begin
			next_st.wrPtr = st.wrPtr + 1'b1;
		end
		if (outReady && !empty) begin
			next_st.rdPtr = st.rdPtr + 1'b1;
		end
		next_st.ready = !((next_st.wrPtr[AW-1:0] == next_st.rdPtr[AW-1:0]) && (next_st.wrPtr[AW] != next_st.rdPtr[AW]));
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st <= '0;
			st.ready <= 1'b1;
		end else begin
			st <= next_st;
		end
		if (inValid && !full) begin
			mem[st.wrPtr[AW-1:0]] <= inData;
		end
	end
endmodule

/* tb/cbt_target_model.sv */
`timescale 1ns/1ps
module cbt_target_model (
	input logic clk_sys,
	input logic slow,
	input logic tgtStrobe,
	input cbt_pkg::cbt_tgt_t tgtOut,
	output logic target_transfer_ack,
	output logic [15:0] tgtRdata
);
	logic [3:0] age = 4'h0;
	always_ff @(posedge clk_sys) begin
		age <= (tgtStrobe && !target_transfer_ack) ? age + 4'h1 : 4'h0;
	end
	// An ack in the fourth strobe clock gives the shortest four-clock cycle; slow mode stalls the bridge.
	assign target_transfer_ack = tgtStrobe && age == (slow ? 4'h9 : 4'h3);
	assign tgtRdata = target_transfer_ack ? tgtOut.addr[15:0] : ~tgtOut.addr[15:0];
endmodule

/* tb/cbt_monitor.sv */
`timescale 1ns/1ps
module cbt_monitor (
	input logic clk_sys,
	input logic srst,
	input logic burst_inhibit_input,
	input logic auto_acknowledge_input,
	input logic reqValid,
	input logic reqReady,
	input logic hostDone,
	input logic protocolError,
	input logic tgtStrobe,
	input cbt_pkg::cbt_tgt_t tgtOut,
	input logic target_transfer_ack
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_ack;
		tgtStrobe && target_transfer_ack;
	endsequence
	sequence s_next;
		!tgtStrobe ##[0:3] (hostDone || tgtStrobe);
	endsequence
	chk_done_tail: assert property (hostDone |-> $past(tgtStrobe, 4) && !$past(tgtStrobe, 3))
		else $error("done without final ack");
	chk_ack_next: assert property (s_ack |=> s_next)
		else $error("late step after ack");
	chk_strobe_hold: assert property (tgtStrobe && !target_transfer_ack |=> tgtStrobe)
		else $error("strobe dropped early");
	chk_out_stable: assert property (tgtStrobe && $past(tgtStrobe) |-> $stable(tgtOut))
		else $error("target outputs moved");
	chk_fc_code: assert property (tgtStrobe |-> tgtOut.fc inside {3'h1, 3'h2})
		else $error("bad function code");
	chk_done_pulse: assert property (hostDone |=> !hostDone)
		else $error("done too long");
	chk_err_sticky: assert property (protocolError |=> protocolError)
		else $error("error flag lost");
	chk_err_flag: assert property (reqValid && reqReady && (!burst_inhibit_input || !auto_acknowledge_input) |=> protocolError)
		else $error("host contract breach not flagged");
endmodule
bind cycle_bridge_timing cbt_monitor u_mon (.clk_sys, .srst, .burst_inhibit_input, .auto_acknowledge_input, .reqValid, .reqReady,
	.hostDone, .protocolError, .tgtStrobe, .tgtOut, .target_transfer_ack);

/* tb/cycle_bridge_timing_tb.sv */
`timescale 1ns/1ps
module cycle_bridge_timing_tb;
	logic clk_sys = 1'h0;
	logic srst = 1'h1;
	logic widthSelect = 1'h1;
	logic burst_inhibit_input = 1'h1;
	logic auto_acknowledge_input = 1'h1;
	logic reqValid = 1'h0;
	logic slow = 1'h0;
	logic reqReady, hostDone, protocolError, tgtStrobe, target_transfer_ack, prev;
	logic [31:0] hostRdata;
	logic [15:0] tgtRdata;
	cbt_pkg::cbt_req_t reqData = '0;
	cbt_pkg::cbt_tgt_t tgtOut;
	int n_fail = 0;
	int n_checks = 0;
	int cyc, beats;
	always #4 clk_sys = ~clk_sys;
	cycle_bridge_timing dut (.clk_sys, .srst, .widthSelect, .burst_inhibit_input, .auto_acknowledge_input,
		.reqValid, .reqReady, .reqData, .hostDone, .hostRdata, .protocolError, .tgtStrobe, .tgtOut,
		.target_transfer_ack, .tgtRdata);
	cbt_target_model far (.clk_sys, .slow, .tgtStrobe, .tgtOut, .target_transfer_ack, .tgtRdata);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Size codes: 0 long, 1 byte, 2 word, 3 line. Queue and pop add two clocks to the bridged count.
	task automatic access(input logic w16, input logic [1:0] sz, input logic wr, input int total, input int nb,
		input logic [31:0] rd);
		@(posedge clk_sys);
		widthSelect <= w16;
		reqData <= '{32'hA5123450, sz, wr, wr, 32'hC3A55A3C};
		reqValid <= 1'h1;
		@(posedge clk_sys);
		reqValid <= 1'h0;
		cyc = 0;
		beats = 0;
		prev = 1'h0;
		while (hostDone !== 1'h1 && cyc < 400) begin
			@(posedge clk_sys);
			#1;
			cyc++;
			if (tgtStrobe && !prev && beats++ == 0) begin
				check(tgtOut.addr, 24'h123450);
				check(tgtOut.fc, wr ? cbt_pkg::FC_PROG[2:0] : cbt_pkg::FC_DATA[2:0]);
				check(tgtOut.write, wr);
				check(tgtOut.wdata, w16 ? 16'hC3A5 : 16'h00C3);
			end
			prev = tgtStrobe;
		end
		check(hostDone, 1'h1);
		if (hostDone !== 1'h1) tally_and_finish;
		check(cyc, total + 2);
		check(beats, nb);
		if (rd != 0) check(hostRdata, rd);
	endtask
	task automatic t_wide;
		access(1'h1, 2'h1, 1'h0, 7, 1, 0);
		access(1'h1, 2'h2, 1'h1, 7, 1, 0);
		access(1'h1, 2'h0, 1'h0, 13, 2, 32'h34503452);
		access(1'h1, 2'h0, 1'h1, 12, 2, 0);
		access(1'h1, 2'h3, 1'h0, 49, 8, 0);
		access(1'h1, 2'h3, 1'h1, 42, 8, 0);
		$display("wide timing end");
	endtask
	task automatic t_narrow;
		access(1'h0, 2'h1, 1'h0, 7, 1, 0);
		access(1'h0, 2'h2, 1'h0, 13, 2, 0);
		access(1'h0, 2'h2, 1'h1, 12, 2, 0);
		access(1'h0, 2'h0, 1'h0, 25, 4, 32'h50515253);
		access(1'h0, 2'h0, 1'h1, 22, 4, 0);
		access(1'h0, 2'h3, 1'h0, 97, 16, 0);
		access(1'h0, 2'h3, 1'h1, 82, 16, 0);
		$display("narrow timing end");
	endtask
	// The target stalls so the queue fills until it refuses, then every taken access must complete.
	task automatic t_fifo;
		int acc = 0;
		int done = 0;
		@(posedge clk_sys);
		slow <= 1'h1;
		reqValid <= 1'h1;
		@(negedge clk_sys);
		while (reqReady === 1'h1 && acc < 20) begin
			acc++;
			@(negedge clk_sys);
		end
		@(posedge clk_sys);
		reqValid <= 1'h0;
		check(acc, cbt_pkg::FIFO_DEPTH + 1);
		for (int i = 0; i < 3000 && done < acc; i++) begin
			@(posedge clk_sys);
			#1;
			if (hostDone) done++;
		end
		check(done, acc);
		$display("queue end");
	endtask
	task automatic t_error;
		@(posedge clk_sys);
		slow <= 1'h0;
		burst_inhibit_input <= 1'h0;
		reqValid <= 1'h1;
		@(posedge clk_sys);
		reqValid <= 1'h0;
		burst_inhibit_input <= 1'h1;
		repeat (2) @(posedge clk_sys);
		#1;
		check(protocolError, 1'h1);
		@(posedge clk_sys);
		srst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'h0;
		@(posedge clk_sys);
		#1;
		check({protocolError, tgtStrobe, reqReady}, 3'h1);
		@(posedge clk_sys);
		auto_acknowledge_input <= 1'h0;
		reqValid <= 1'h1;
		@(posedge clk_sys);
		reqValid <= 1'h0;
		auto_acknowledge_input <= 1'h1;
		repeat (2) @(posedge clk_sys);
		#1;
		check(protocolError, 1'h1);
		$display("error end");
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		srst <= 1'h0;
		t_wide;
		t_narrow;
		t_fifo;
		t_error;
		tally_and_finish;
	end
endmodule
